// >>> common/adc_ctrl_pkg.sv
// Package: constants for converter reset and conversion control
package adc_ctrl_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned DATA_W          = 18;
  // Power-on reset stretch
  localparam int unsigned POR_CYCLES      = 16;
  localparam logic [4:0]  POR_CNT_RST     = 5'h00;
  // Trim-load conversions
  localparam int unsigned TRIM_CONV       = 3;
  localparam logic [1:0]  TRIM_CNT_RST    = 2'h0;
  localparam logic [1:0]  TRIM_CNT_DONE   = 2'(TRIM_CONV);
  // Conversion timing
  localparam int unsigned CONV_TIME_NS    = 700;
  localparam int unsigned CONV_CYCLES     = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REQ_MIN_NS      = 20;
  localparam int unsigned REQ_MIN_CYC     = (REQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SELF_RST_CYCLES = 4;
  localparam logic [DATA_W-1:0] DATA_RST  = 18'h0_0000;
  localparam int unsigned CNT_W           = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 8'h00;

  typedef enum logic [3:0] {
    ST_POR    = 4'b0001,
    ST_SAMPLE = 4'b0010,
    ST_CONV   = 4'b0100,
    ST_SRST   = 4'b1000
  } conv_state_e;
endpackage : adc_ctrl_pkg

// >>> core/adc_edge_sync.sv
// Two-flop synchroniser with falling-edge detect for one strobe pin
`timescale 1ns/1ps
module adc_edge_sync (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // Pin and result
  input  wire logic pin_n,
  output logic      level_n,
  output logic      fall
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  // Idle level of the strobes is high
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      meta_r <= pin_n;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level_n = sync_r;
  assign fall    = prev_r & ~sync_r;
endmodule // adc_edge_sync

// >>> core/adc_conversion_reset_control.sv
// Conversion, trim-discard and self-clearing reset control of the converter
//
// Functional notes
// - Power-on reset generated internally, no reset pin.
// - First three conversions load trim, invalid.
// - Request fall with select low while busy resets.
// - Select falling edge while busy resets.
// - Reset self-clears and aborts running conversion.
// - Reset end clears all output latches.
// - Reset end drives busy low.
// - New sampling period starts at busy fall.
// - Busy rises on request fall, falls at end.
// - Bus driven only while select and read low.
`timescale 1ns/1ps
module adc_conversion_reset_control (
  // Clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              reset,
  // Host strobes
  input  wire logic                              convert_request_n,
  input  wire logic                              chip_select_n,
  input  wire logic                              read_n,
  // Sample from the converter core
  input  wire logic [adc_ctrl_pkg::DATA_W-1:0]   sample_data,
  // Status and data bus
  output logic                                   busy,
  output logic                                   sampling,
  output logic                                   result_valid,
  output logic [adc_ctrl_pkg::DATA_W-1:0]        data_out,
  output logic [adc_ctrl_pkg::DATA_W-1:0]        data_oe
);
  import adc_ctrl_pkg::*;

  logic                 cs_level_n;
  logic                 cs_fall;
  logic                 cr_level_n;
  logic                 cr_fall;
  logic                 rd_level_n;
  conv_state_e          state_r;
  logic [4:0]           por_cnt_r;
  logic [CNT_W-1:0]     cnt_r;
  logic [1:0]           trim_cnt_r;
  logic [DATA_W-1:0]    latch_r;
  logic                 conv_done;
  logic                 start_conv;
  logic                 reset_req;
  logic                 por_end;
  logic                 srst_end;

  // ****************************************
  // Decode helpers
  // ****************************************
  // Terminal count of the shared counter for a run of len cycles
  function automatic logic cnt_is_last(
    input logic [CNT_W-1:0] cnt,
    input int unsigned      len
  );
    return cnt == CNT_W'(len - 1);
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  adc_edge_sync u_cs_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .pin_n   (chip_select_n),
    .level_n (cs_level_n),
    .fall    (cs_fall)
  );

  adc_edge_sync u_cr_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .pin_n   (convert_request_n),
    .level_n (cr_level_n),
    .fall    (cr_fall)
  );

  // Read strobe matters only as a level
  adc_edge_sync u_rd_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .pin_n   (read_n),
    .level_n (rd_level_n),
    .fall    ()
  );

  // ****************************************
  // Event decode
  // ****************************************
  // Request is honoured only with select low at its falling edge
  assign start_conv = (state_r == ST_SAMPLE) && cr_fall && !cs_level_n;
  // A select fall, or a request fall with select low, during a conversion restarts the converter
  assign reset_req  = (state_r == ST_CONV) &&
                      ((cr_fall && !cs_level_n) || cs_fall);
  // A strobe on the last count still aborts; that result is dropped
  assign conv_done  = (state_r == ST_CONV) && cnt_is_last(cnt_r, CONV_CYCLES) && !reset_req;
  assign srst_end   = (state_r == ST_SRST) && cnt_is_last(cnt_r, SELF_RST_CYCLES);
  assign por_end    = (state_r == ST_POR) && (por_cnt_r == 5'(POR_CYCLES - 1));

  // ****************************************
  // Control state
  // ****************************************
  // The async reset stands in for the supply ramp; the stretch
  // below is the device's own power-on reset, no pin involved.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= ST_POR;
    end else begin
      case (state_r)
        ST_POR: begin
          if (por_end) begin
            state_r <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (start_conv) begin
            state_r <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (reset_req) begin
            state_r <= ST_SRST;
          end else if (conv_done) begin
            state_r <= ST_SAMPLE;
          end
        end
        ST_SRST: begin
          if (srst_end) begin
            state_r <= ST_SAMPLE;
          end
        end
        default: state_r <= ST_POR;
      endcase
    end
  end

  // ****************************************
  // Counters
  // ****************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      por_cnt_r <= POR_CNT_RST;
    end else if (state_r == ST_POR) begin
      por_cnt_r <= por_cnt_r + 5'h01;
    end
  end

  // Shared by conversion timing and self-reset stretch
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= CNT_ZERO;
    end else if (start_conv || reset_req || conv_done) begin
      cnt_r <= CNT_ZERO;
    end else if (state_r == ST_CONV || state_r == ST_SRST) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  // Aborted conversions do not count toward trim loading
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      trim_cnt_r <= TRIM_CNT_RST;
    end else if (conv_done && trim_cnt_r != TRIM_CNT_DONE) begin
      trim_cnt_r <= trim_cnt_r + 2'h1;
    end
  end

  // ****************************************
  // Output latch and status
  // ****************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      latch_r <= DATA_RST;
    end else if (state_r == ST_SRST) begin
      latch_r <= DATA_RST;
    end else if (conv_done) begin
      latch_r <= sample_data;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      busy         <= 1'b0;
      sampling     <= 1'b0;
      result_valid <= 1'b0;
    end else begin
      // Busy covers conversion and self-reset; drops when reset ends
      busy         <= (state_r == ST_CONV && !conv_done) || start_conv ||
                      (state_r == ST_SRST && !srst_end);
      sampling     <= (state_r == ST_SAMPLE && !start_conv) ||
                      conv_done ||
                      srst_end ||
                      por_end;
      // Trim conversions never show as valid
      if (state_r == ST_SRST) begin
        result_valid <= 1'b0;
      end else if (conv_done) begin
        result_valid <= (trim_cnt_r == TRIM_CNT_DONE);
      end
    end
  end

  // ****************************************
  // Parallel bus
  // ****************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      data_out <= DATA_RST;
      data_oe  <= DATA_RST;
    end else begin
      data_out <= latch_r;
      data_oe  <= {DATA_W{!cs_level_n && !rd_level_n}};
    end
  end
endmodule // adc_conversion_reset_control

// >>> test/adc_ctrl_props.sv
// Concurrent checks for converter reset and conversion control
`timescale 1ns/1ps
module adc_ctrl_props (
  // Clock and reset
  input wire logic                            sys_clk,
  input wire logic                            reset,
  // Strobes and outputs
  input wire logic                            convert_request_n,
  input wire logic                            chip_select_n,
  input wire logic                            read_n,
  input wire logic                            busy,
  input wire logic                            sampling,
  input wire logic                            result_valid,
  input wire logic [adc_ctrl_pkg::DATA_W-1:0] data_out,
  input wire logic [adc_ctrl_pkg::DATA_W-1:0] data_oe
);
  import adc_ctrl_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Abort causes and the state they must leave
  sequence s_cs_abort; busy && $fell(chip_select_n); endsequence
  sequence s_rq_abort; busy && !chip_select_n && $fell(convert_request_n); endsequence
  sequence s_cleared; !busy && sampling && !result_valid && data_out == DATA_RST; endsequence
  property p_por; $fell(reset) |-> (!busy && !sampling) [*8]; endproperty
  property p_start; sampling && !busy && !chip_select_n && $fell(convert_request_n) |-> ##[1:6] busy; endproperty
  property p_hold; $rose(busy) |-> busy [*6]; endproperty
  property p_cs_rst; s_cs_abort |-> ##[1:12] s_cleared; endproperty
  property p_rq_rst; s_rq_abort |-> ##[1:12] s_cleared; endproperty
  property p_sample; $fell(busy) |-> sampling; endproperty
  property p_oe_off; (chip_select_n || read_n) [*4] |-> data_oe == '0; endproperty
  property p_oe_on; (!chip_select_n && !read_n) [*4] |-> &data_oe; endproperty
  property p_valid; $rose(result_valid) |-> !busy && sampling; endproperty
  a_por: assert property (p_por) else $error("busy or sampling during power-up");
  a_start: assert property (p_start) else $error("busy late after request");
  a_hold: assert property (p_hold) else $error("busy pulse too short");
  a_cs_rst: assert property (p_cs_rst) else $error("select abort did not clear");
  a_rq_rst: assert property (p_rq_rst) else $error("request abort did not clear");
  a_sample: assert property (p_sample) else $error("no sampling after busy fall");
  a_oe_off: assert property (p_oe_off) else $error("bus driven while deselected");
  a_oe_on: assert property (p_oe_on) else $error("bus not driven on read");
  a_valid: assert property (p_valid) else $error("valid rose mid conversion");
endmodule // adc_ctrl_props

bind adc_conversion_reset_control adc_ctrl_props u_adc_ctrl_props (.sys_clk(sys_clk), .reset(reset),
  .convert_request_n(convert_request_n), .chip_select_n(chip_select_n), .read_n(read_n), .busy(busy),
  .sampling(sampling), .result_valid(result_valid), .data_out(data_out), .data_oe(data_oe));

// >>> test/adc_host_model.sv
// Host model: drives strobes and supplies the core sample
`timescale 1ns/1ps
module adc_host_model (
  // Clock and status
  input wire logic                       sys_clk,
  input wire logic                       busy,
  // Strobes and core sample
  output logic                           convert_request_n,
  output logic                           chip_select_n,
  output logic                           read_n,
  output logic [adc_ctrl_pkg::DATA_W-1:0] sample_data
);
  import adc_ctrl_pkg::*;
  initial begin
    convert_request_n = 1'b1;
    chip_select_n = 1'b1;
    read_n = 1'b1;
    sample_data = DATA_RST;
  end
  // Set pins at an edge, then hold them n cycles
  task automatic pins(input logic cs, input logic cv, input logic rd, input int n);
    @(posedge sys_clk);
    chip_select_n <= cs;
    convert_request_n <= cv;
    read_n <= rd;
    repeat (n - 1) @(posedge sys_clk);
  endtask
  // Start only when idle, else the strobe would reset the part
  task automatic convert(input logic [DATA_W-1:0] d);
    int i;
    for (i = 0; i < 200 && busy !== 1'b0; i++) @(posedge sys_clk);
    pins(1'b0, 1'b1, 1'b1, 2);
    sample_data <= d;
    pins(1'b0, 1'b0, 1'b1, REQ_MIN_CYC + 1);
    pins(1'b0, 1'b1, 1'b1, 1);
  endtask
endmodule // adc_host_model

// >>> test/adc_conversion_reset_control_tb.sv
// Self-checking bench for converter reset and conversion control
`timescale 1ns/1ps
module adc_conversion_reset_control_tb;
  import adc_ctrl_pkg::*;
  logic              sys_clk = 1'b0;
  logic              reset = 1'b1;
  logic              convert_request_n, chip_select_n, read_n, busy, sampling, result_valid;
  logic [DATA_W-1:0] sample_data, data_out, data_oe;
  int                err_count = 0;
  int                compares = 0;
  int                cycles = 0;
  always #5 sys_clk = ~sys_clk;
  adc_host_model u_adc_host_model (.sys_clk(sys_clk), .busy(busy), .convert_request_n(convert_request_n),
    .chip_select_n(chip_select_n), .read_n(read_n), .sample_data(sample_data));
  adc_conversion_reset_control u_adc_conversion_reset_control (.sys_clk(sys_clk), .reset(reset),
    .convert_request_n(convert_request_n), .chip_select_n(chip_select_n), .read_n(read_n),
    .sample_data(sample_data), .busy(busy), .sampling(sampling), .result_valid(result_valid),
    .data_out(data_out), .data_oe(data_oe));
  task automatic chk(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic conclude();
    if (err_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Hang guard, far above the several hundred cycles needed
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      conclude();
    end
  end
  task automatic wait_idle();
    int i;
    @(negedge sys_clk);
    for (i = 0; i < 200 && busy !== 1'b0; i++) @(negedge sys_clk);
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic t_por();
    repeat (8) @(negedge sys_clk);
    chk("por busy", '0, DATA_W'(busy));
    chk("por sampling", '0, DATA_W'(sampling));
    repeat (12) @(negedge sys_clk);
    chk("por done", 18'h0_0001, DATA_W'(sampling));
  endtask
  // First three results are trim loads; host ignores them
  task automatic t_trim();
    int k;
    for (k = 0; k < 4; k++) begin
      u_adc_host_model.convert(18'h2_A5C3 ^ DATA_W'(k));
      @(negedge sys_clk);
      chk("busy rise", 18'h0_0001, DATA_W'(busy));
      repeat (CONV_CYCLES - 20) @(negedge sys_clk);
      chk("busy hold", 18'h0_0001, DATA_W'(busy));
      wait_idle();
      chk("valid", DATA_W'(k == 3), DATA_W'(result_valid));
      if (k == 3) chk("data", 18'h2_A5C3 ^ 18'h0_0003, data_out);
      u_adc_host_model.pins(1'b0, 1'b1, 1'b0, 5);
      @(negedge sys_clk);
      chk("oe on", '1, data_oe);
      u_adc_host_model.pins(1'b1, 1'b1, 1'b1, 5);
      @(negedge sys_clk);
      chk("oe off", '0, data_oe);
    end
  endtask
  // Strobe in mid conversion, then a clean one after
  task automatic t_abort(input logic by_cs);
    u_adc_host_model.convert(18'h1_5A3C);
    repeat (20) @(posedge sys_clk);
    // Select rises then falls, or request falls with select low
    u_adc_host_model.pins(by_cs, by_cs, 1'b1, 3);
    u_adc_host_model.pins(1'b0, 1'b1, 1'b1, 1);
    repeat (12) @(negedge sys_clk);
    chk("abort busy", '0, DATA_W'(busy));
    chk("abort data", DATA_RST, data_out);
    chk("abort valid", '0, DATA_W'(result_valid));
    chk("abort sampling", 18'h0_0001, DATA_W'(sampling));
    u_adc_host_model.convert(18'h0_7E81);
    wait_idle();
    chk("after valid", 18'h0_0001, DATA_W'(result_valid));
    chk("after data", 18'h0_7E81, data_out);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    t_por();
    t_trim();
    t_abort(1'b1);
    t_abort(1'b0);
    conclude();
  end
endmodule // adc_conversion_reset_control_tb
